//--- src/ucp_pkg.sv
// ucp_pkg: shared constants and types for the cell port link
// assumes both ends run on one system clock, link clock sampled
package ucp_pkg;
    localparam int         UCP_PORTS       = 4;
    localparam int         UCP_ADDR_W      = 5;
    localparam int         UCP_CELL_BYTES  = 53;
    localparam logic [4:0] UCP_FIRST_PORT  = 5'h00;
    localparam logic [4:0] UCP_NULL_ADDR   = 5'h1F;
    localparam logic [5:0] UCP_LAST_BYTE   = 6'h34;
    localparam logic [5:0] UCP_BYTE_ZERO   = 6'h00;
    localparam logic [7:0] UCP_BYTE_IDLE   = 8'h00;
    localparam logic [2:0] UCP_RX_LAT      = 3'h2;
    localparam int         UCP_LCLK_DIV    = 4;
    localparam logic [1:0] UCP_MODE_DIRECT = 2'h0;
    typedef enum logic [1:0] {
        UCP_RX_IDLE  = 2'b00,
        UCP_RX_WAIT  = 2'b01,
        UCP_RX_SEND  = 2'b10,
        UCP_RX_HOLD  = 2'b11
    } ucp_rx_state_t;
endpackage

//--- src/ucp_link_if.sv
// ucp_link_if: cell port link between phy end and atm master end
// assumes the bench drives link_clk and joins both modports
`timescale 1ns/1ps
`default_nettype none
interface ucp_link_if;
    logic       link_clk;
    logic [4:0] tx_port_select;
    logic       tx_write_strobe_n;
    logic [7:0] tx_cell_byte_lines;
    logic       tx_cell_start;
    logic [3:0] tx_direct_room_flag;
    logic       tx_polled_room_flag;
    logic [4:0] rx_port_select;
    logic       rx_read_strobe_n;
    logic [7:0] rx_cell_byte_lines;
    logic       rx_cell_start;
    logic       rx_drive_en;
    logic       rx_polled_cell_ready;
    // phy end: drives flags and receive data
    modport phy (
        input  link_clk, tx_port_select, tx_write_strobe_n, tx_cell_byte_lines,
               tx_cell_start, rx_port_select, rx_read_strobe_n,
        output tx_direct_room_flag, tx_polled_room_flag, rx_cell_byte_lines,
               rx_cell_start, rx_drive_en, rx_polled_cell_ready
    );
    // atm end: master, selects and strobes
    modport atm (
        input  link_clk, tx_direct_room_flag, tx_polled_room_flag,
               rx_cell_byte_lines, rx_cell_start, rx_drive_en, rx_polled_cell_ready,
        output tx_port_select, tx_write_strobe_n, tx_cell_byte_lines, tx_cell_start,
               rx_port_select, rx_read_strobe_n
    );
endinterface
`default_nettype wire

//--- src/ucp_atm_end.sv
// ucp_atm_end: atm side master moving whole cells over the link
// assumes user holds request until accepted; link clock is not used here
`timescale 1ns/1ps
`default_nettype none
module ucp_atm_end
    import ucp_pkg::*;
(
    // system
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    // link
    ucp_link_if.atm         link,
    // transmit user side
    input  wire logic       tx_req_in,
    input  wire logic [4:0] tx_port_in,
    input  wire logic [7:0] tx_byte_in,
    output logic            tx_ack_out,
    output logic            tx_busy_out,
    // receive user side
    input  wire logic       rx_req_in,
    input  wire logic [4:0] rx_port_in,
    output logic            rx_valid_out,
    output logic            rx_sop_out,
    output logic [7:0]      rx_byte_out,
    output logic            rx_busy_out
);
    typedef struct packed {
        logic       tx_act;
        logic       tx_arm;
        logic [5:0] tx_cnt;
        logic [4:0] tx_sel;
        logic       tx_en_n;
        logic       tx_sop;
        logic [7:0] tx_dat;
        logic       rx_act;
        logic       rx_arm;
        logic [5:0] rx_cnt;
        logic [4:0] rx_sel;
        logic       rx_en_n;
        logic       rx_v;
        logic       rx_s;
        logic [7:0] rx_d;
    } ucp_atm_st_t;
    ucp_atm_st_t st_r;
    ucp_atm_st_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.tx_sop = 1'b0;
        st_nxt.rx_v = 1'b0;
        st_nxt.rx_s = 1'b0;
        // transmit: select, then enable with first byte and start
        if (!st_r.tx_act && tx_req_in) begin
            st_nxt.tx_act = 1'b1;
            st_nxt.tx_arm = 1'b1;
            st_nxt.tx_sel = tx_port_in;
            st_nxt.tx_en_n = 1'b1;
        end else if (st_r.tx_arm) begin
            st_nxt.tx_arm = 1'b0;
            st_nxt.tx_en_n = 1'b0;
            st_nxt.tx_sop = 1'b1;
            st_nxt.tx_dat = tx_byte_in;
            st_nxt.tx_cnt = UCP_BYTE_ZERO;
        end else if (st_r.tx_act) begin
            // poll the next wanted port while the cell runs
            st_nxt.tx_sel = tx_port_in;
            if (st_r.tx_cnt == UCP_LAST_BYTE) begin
                st_nxt.tx_act = 1'b0;
                st_nxt.tx_en_n = 1'b1;
            end else begin
                st_nxt.tx_cnt = st_r.tx_cnt + 6'h01;
                st_nxt.tx_dat = tx_byte_in;
            end
        end
        // receive: select, enable one cycle later, take 53 bytes
        if (!st_r.rx_act && rx_req_in) begin
            st_nxt.rx_act = 1'b1;
            st_nxt.rx_arm = 1'b1;
            st_nxt.rx_sel = rx_port_in;
            st_nxt.rx_en_n = 1'b1;
            st_nxt.rx_cnt = UCP_BYTE_ZERO;
        end else if (st_r.rx_arm) begin
            st_nxt.rx_arm = 1'b0;
            st_nxt.rx_en_n = 1'b0;
        end else if (st_r.rx_act && link.rx_drive_en) begin
            if (link.rx_cell_start || st_r.rx_cnt != UCP_BYTE_ZERO) begin
                st_nxt.rx_v = 1'b1;
                st_nxt.rx_s = link.rx_cell_start;
                st_nxt.rx_d = link.rx_cell_byte_lines;
                st_nxt.rx_cnt = st_r.rx_cnt + 6'h01;
                if (st_r.rx_cnt == UCP_LAST_BYTE) begin
                    st_nxt.rx_act = 1'b0;
                    st_nxt.rx_en_n = 1'b1;
                end
            end
        end
        if (!rst_n_in) begin
            st_nxt = '0;
            st_nxt.tx_en_n = 1'b1;
            st_nxt.rx_en_n = 1'b1;
            st_nxt.tx_sel = UCP_NULL_ADDR;
            st_nxt.rx_sel = UCP_NULL_ADDR;
        end
    end

    // state register
    always_ff @(posedge clk_sys_in) begin
        st_r <= st_nxt;
    end

    // outputs
    assign link.tx_port_select     = st_r.tx_sel;
    assign link.tx_write_strobe_n  = st_r.tx_en_n;
    assign link.tx_cell_byte_lines = st_r.tx_dat;
    assign link.tx_cell_start      = st_r.tx_sop;
    assign link.rx_port_select     = st_r.rx_sel;
    assign link.rx_read_strobe_n   = st_r.rx_en_n;
    assign tx_ack_out   = st_r.tx_arm || (st_r.tx_act && !st_r.tx_en_n
                          && st_r.tx_cnt != UCP_LAST_BYTE);
    assign tx_busy_out  = st_r.tx_act;
    assign rx_valid_out = st_r.rx_v;
    assign rx_sop_out   = st_r.rx_s;
    assign rx_byte_out  = st_r.rx_d;
    assign rx_busy_out  = st_r.rx_act;
endmodule
`default_nettype wire

//--- src/ucp_phy_end.sv
// ucp_phy_end: phy side of the cell port, four ports, direct and polled
// assumes atm master on the same system clock; link clock sampled only
// link clock is only watched here, cells move on the system clock
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - first port answers select code 00h
// - direct tx flag per port when room
// - master strobes first byte with start
// - master drops start, sends remaining bytes
// - drop direct flag without whole-cell room
// - master deasserts enable while reselecting port
// - polled tx flag two edges after poll
// - master may poll during a transfer
// - polled rx flag only with whole cell
// - drop rx flag without another cell
// - master enables receive one cycle after select
// - first byte and start two cycles later
// - drop rx start after first byte
// - master deasserts rx enable when switching
// - old port releases, new starts next cycle
module ucp_phy_end
    import ucp_pkg::*;
(
    // system
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    // link
    ucp_link_if.phy         link,
    // per port transmit room and receive cell status
    input  wire logic [3:0] tx_room_in,
    input  wire logic [3:0] rx_cell_ready_in,
    // receive data source, byte for current port and index
    input  wire logic [7:0] rx_src_byte_in,
    output logic [4:0]      rx_src_port_out,
    output logic [5:0]      rx_src_index_out,
    output logic            rx_cell_done_out,
    // transmit sink
    output logic            tx_byte_valid_out,
    output logic            tx_byte_sop_out,
    output logic [7:0]      tx_byte_out,
    output logic [4:0]      tx_byte_port_out,
    // observed link clock edge
    output logic            link_clk_rise_out
);
    typedef struct packed {
        // link clock sampling
        logic [1:0]    lclk_sync;
        logic          lclk_prev;
        logic          lclk_rise;
        // transmit side: polled address, target port, captured byte
        logic [4:0]    tx_sel;
        logic [4:0]    tx_cur;
        logic          tx_pflag;
        logic          tx_v;
        logic          tx_s;
        logic [7:0]    tx_d;
        logic [4:0]    tx_p;
        // receive side: polled address, sequencer, output byte
        logic [4:0]    rx_sel;
        logic          rx_pflag;
        ucp_rx_state_t rx_st;
        logic [2:0]    rx_wait;
        logic [4:0]    rx_port;
        logic [5:0]    rx_idx;
        logic          rx_drv;
        logic          rx_sop;
        logic [7:0]    rx_dat;
        logic          rx_done;
    } ucp_phy_st_t;
    ucp_phy_st_t st_r;
    ucp_phy_st_t st_nxt;

    // addressed port valid check
    // codes above the last port are ignored, so an idle select is safe
    function automatic logic ucp_port_ok(input logic [4:0] a);
        ucp_port_ok = (a - UCP_FIRST_PORT) < 5'(UCP_PORTS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.tx_v = 1'b0;
        st_nxt.tx_s = 1'b0;
        st_nxt.rx_done = 1'b0;
        // link clock through two flops, then edge detect
        // the first flop may go metastable, only the second is read
        st_nxt.lclk_sync = {st_r.lclk_sync[0], link.link_clk};
        st_nxt.lclk_prev = st_r.lclk_sync[1];
        st_nxt.lclk_rise = st_r.lclk_sync[1] && !st_r.lclk_prev;

        ////////////////////////////////////////////////////////////////////
        // transmit poll: address sampled on one edge, flag on the next,
        // so the flag answers two edges after the master polls
        st_nxt.tx_sel = link.tx_port_select;
        st_nxt.tx_pflag = ucp_port_ok(st_r.tx_sel)
                          && tx_room_in[st_r.tx_sel[1:0]];
        // target port taken while the strobe is high; a poll issued
        // during a cell moves the select bus but not the target
        if (link.tx_write_strobe_n) begin
            st_nxt.tx_cur = link.tx_port_select;
        end
        // transmit byte capture under active low strobe
        if (!link.tx_write_strobe_n && ucp_port_ok(st_r.tx_cur)) begin
            st_nxt.tx_v = 1'b1;
            st_nxt.tx_s = link.tx_cell_start;
            st_nxt.tx_d = link.tx_cell_byte_lines;
            st_nxt.tx_p = st_r.tx_cur;
        end

        ////////////////////////////////////////////////////////////////////
        // receive poll flag: only with a whole cell ready
        st_nxt.rx_sel = link.rx_port_select;
        st_nxt.rx_pflag = ucp_port_ok(st_r.rx_sel)
                          && rx_cell_ready_in[st_r.rx_sel[1:0]];

        ////////////////////////////////////////////////////////////////////
        // receive cell sequencer
        case (st_r.rx_st)
            // idle: wait for the strobe on a valid port
            UCP_RX_IDLE: begin
                st_nxt.rx_drv = 1'b0;
                st_nxt.rx_sop = 1'b0;
                if (!link.rx_read_strobe_n && ucp_port_ok(link.rx_port_select)) begin
                    st_nxt.rx_st = UCP_RX_WAIT;
                    st_nxt.rx_port = link.rx_port_select;
                    // idle and wait steps already use two edges of latency
                    st_nxt.rx_wait = UCP_RX_LAT - 3'h2;
                end
            end
            // wait: count out the latency, start only with a whole cell
            // so a port that has nothing simply holds off the master
            UCP_RX_WAIT: begin
                if (link.rx_read_strobe_n) begin
                    st_nxt.rx_st = UCP_RX_IDLE;
                end else if (st_r.rx_wait == 3'h0) begin
                    if (rx_cell_ready_in[st_r.rx_port[1:0]]) begin
                        st_nxt.rx_st = UCP_RX_SEND;
                        st_nxt.rx_drv = 1'b1;
                        st_nxt.rx_sop = 1'b1;
                        st_nxt.rx_idx = UCP_BYTE_ZERO;
                        st_nxt.rx_dat = rx_src_byte_in;
                    end
                end else begin
                    st_nxt.rx_wait = st_r.rx_wait - 3'h1;
                end
            end
            // send: one byte a cycle; a raised strobe parks the port
            // with its last byte still driven until it is released
            UCP_RX_SEND: begin
                st_nxt.rx_sop = 1'b0;
                if (st_r.rx_idx == UCP_LAST_BYTE) begin
                    st_nxt.rx_st = UCP_RX_HOLD;
                    st_nxt.rx_drv = 1'b0;
                    st_nxt.rx_done = 1'b1;
                end else if (link.rx_read_strobe_n) begin
                    st_nxt.rx_st = UCP_RX_HOLD;
                end else begin
                    st_nxt.rx_idx = st_r.rx_idx + 6'h01;
                    st_nxt.rx_dat = rx_src_byte_in;
                end
            end
            UCP_RX_HOLD: begin
                // old port stops one cycle after enable returns
                if (!link.rx_read_strobe_n) begin
                    st_nxt.rx_drv = 1'b0;
                    st_nxt.rx_sop = 1'b0;
                    st_nxt.rx_st = UCP_RX_WAIT;
                    st_nxt.rx_port = link.rx_port_select;
                    st_nxt.rx_wait = 3'h0;
                end
            end
            default: st_nxt.rx_st = UCP_RX_IDLE;
        endcase
        // synchronous reset overrides everything above
        if (!rst_n_in) begin
            st_nxt = '0;
            st_nxt.rx_st = UCP_RX_IDLE;
        end
    end

    // state register, one flop set for the whole state
    always_ff @(posedge clk_sys_in) begin
        st_r <= st_nxt;
    end

    // direct flags per port, room for a whole cell
    assign link.tx_direct_room_flag  = rst_n_in ? tx_room_in : 4'h0;

    // polled flags and receive data, all from flops
    assign link.tx_polled_room_flag  = st_r.tx_pflag;
    assign link.rx_polled_cell_ready = st_r.rx_pflag;
    assign link.rx_cell_byte_lines   = st_r.rx_drv ? st_r.rx_dat : UCP_BYTE_IDLE;
    assign link.rx_cell_start        = st_r.rx_drv && st_r.rx_sop;
    assign link.rx_drive_en          = st_r.rx_drv;

    // source address runs one byte ahead while sending
    assign rx_src_port_out   = st_r.rx_st == UCP_RX_SEND ? st_r.rx_port : link.rx_port_select;
    assign rx_src_index_out  = st_r.rx_st == UCP_RX_SEND ? st_r.rx_idx + 6'h01 : UCP_BYTE_ZERO;
    // user side pulses
    assign rx_cell_done_out  = st_r.rx_done;
    assign tx_byte_valid_out = st_r.tx_v;
    assign tx_byte_sop_out   = st_r.tx_s;
    assign tx_byte_out       = st_r.tx_d;
    assign tx_byte_port_out  = st_r.tx_p;
    assign link_clk_rise_out = st_r.lclk_rise;
endmodule
`default_nettype wire

//--- dv/ucp_link_props.sv
// ucp_link_props: timing checks on the signals of the cell port link
// assumes it sits beside the link instance, all inputs wired by name
`timescale 1ns/1ps
`default_nettype none
module ucp_link_props (
    // system
    input wire logic       clk_sys_in,
    input wire logic       rst_n_in,
    // link
    input wire logic [4:0] tx_port_select,
    input wire logic       tx_write_strobe_n,
    input wire logic       tx_cell_start,
    input wire logic [4:0] rx_port_select,
    input wire logic       rx_read_strobe_n,
    input wire logic       rx_cell_start,
    input wire logic       rx_drive_en
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic [5:0] tx_run_r;
    ////////////////////////////////////////////////////////
    // length of the current tx strobe-low run
    always_ff @(posedge clk_sys_in) begin
        tx_run_r <= (!rst_n_in || tx_write_strobe_n) ? 6'h00 : tx_run_r + 6'h01;
    end
    // transmit side, driven by the atm end
    a_tx_start_first: assert property ($fell(tx_write_strobe_n) |-> tx_cell_start)
        else $error("tx start marker missing on first byte");
    a_tx_start_only: assert property (tx_cell_start |-> !tx_write_strobe_n)
        else $error("tx start marker without strobe");
    a_tx_start_drop: assert property (tx_cell_start |=> !tx_cell_start)
        else $error("tx start marker held past first byte");
    a_tx_sel_hold: assert property ($fell(tx_write_strobe_n) |->
        $stable(tx_port_select) && tx_port_select < 5'h04)
        else $error("tx select not settled before strobe");
    a_tx_cell_len: assert property ($rose(tx_write_strobe_n) |-> tx_run_r == 6'h35)
        else $error("tx cell not 53 bytes long");
    // receive side
    a_rx_sel_hold: assert property ($fell(rx_read_strobe_n) |-> $stable(rx_port_select))
        else $error("rx select changed with strobe");
    a_rx_start_lat: assert property (rx_cell_start |->
        !$past(rx_read_strobe_n, 2) && $past(rx_read_strobe_n, 3))
        else $error("rx first byte not two cycles after strobe");
    a_rx_start_drop: assert property (rx_cell_start |-> rx_drive_en ##1
        (rx_drive_en && !rx_cell_start))
        else $error("rx start marker not single or undriven");
    a_rx_new_drive: assert property ($rose(rx_drive_en) |-> rx_cell_start)
        else $error("rx drive began without start marker");
    a_reset_idle: assert property ($rose(rst_n_in) |->
        tx_write_strobe_n && rx_read_strobe_n && !rx_drive_en)
        else $error("link not idle out of reset");
endmodule
`default_nettype wire

//--- dv/test_utopia_l3_phy_cell_port.sv
// test_utopia_l3_phy_cell_port: both ends joined, user sides driven
// assumes 25 MHz system clock and a free 320 ns link clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module test_utopia_l3_phy_cell_port
    import ucp_pkg::*;
();
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] tx_room = 4'hF;
    logic [3:0] rx_ready = 4'h0;
    logic       tx_req = 1'b0;
    logic       rx_req = 1'b0;
    logic [4:0] tx_port = UCP_NULL_ADDR;
    logic [4:0] rx_port = UCP_NULL_ADDR;
    logic [5:0] tx_idx = 6'h00;
    logic [4:0] exp_tx, exp_rx, src_port, tb_port;
    logic [5:0] src_idx;
    logic [7:0] src_byte, tx_byte, tb_byte, rx_byte;
    logic       tx_ack, tx_busy, rx_valid, rx_sop, rx_busy, tb_valid, tb_sop, done, lrise;
    int         num_errors = 0, num_checks = 0, tx_got = 0, rx_got = 0, done_cnt = 0;
    int         rise_cnt = 0, r0;
    ucp_link_if link ();
    ////////////////////////////////////////////////////////
    // clocks: system 40 ns, link 320 ns with an unrelated phase
    initial forever #20 clk = ~clk;
    initial begin
        link.link_clk = 1'b0;
        #7;
        forever #160 link.link_clk = ~link.link_clk;
    end
    // byte sources follow port and index
    assign src_byte = {src_port[1:0], src_idx};
    assign tx_byte  = {exp_tx[1:0], tx_idx};
    ucp_phy_end i_ucp_phy_end (
        .clk_sys_in (clk), .rst_n_in (rst_n), .link (link.phy),
        .tx_room_in (tx_room), .rx_cell_ready_in (rx_ready), .rx_src_byte_in (src_byte),
        .rx_src_port_out (src_port), .rx_src_index_out (src_idx), .rx_cell_done_out (done),
        .tx_byte_valid_out (tb_valid), .tx_byte_sop_out (tb_sop), .tx_byte_out (tb_byte),
        .tx_byte_port_out (tb_port), .link_clk_rise_out (lrise));
    ucp_atm_end i_ucp_atm_end (
        .clk_sys_in (clk), .rst_n_in (rst_n), .link (link.atm),
        .tx_req_in (tx_req), .tx_port_in (tx_port), .tx_byte_in (tx_byte), .tx_ack_out (tx_ack),
        .tx_busy_out (tx_busy), .rx_req_in (rx_req), .rx_port_in (rx_port),
        .rx_valid_out (rx_valid), .rx_sop_out (rx_sop), .rx_byte_out (rx_byte),
        .rx_busy_out (rx_busy));
    ucp_link_props i_ucp_link_props (
        .clk_sys_in (clk), .rst_n_in (rst_n), .tx_port_select (link.tx_port_select),
        .tx_write_strobe_n (link.tx_write_strobe_n), .tx_cell_start (link.tx_cell_start),
        .rx_port_select (link.rx_port_select), .rx_read_strobe_n (link.rx_read_strobe_n),
        .rx_cell_start (link.rx_cell_start), .rx_drive_en (link.rx_drive_en));
    // user side monitors, pre-edge values
    always @(posedge clk) begin
        if (tx_ack) tx_idx <= tx_idx + 6'h01;
        if (tb_valid) begin
            `CHK(tb_byte, {exp_tx[1:0], tx_got[5:0]})
            `CHK(tb_sop, tx_got == 0)
            `CHK(tb_port, exp_tx)
            tx_got++;
        end
        if (rx_valid) begin
            `CHK(rx_byte, {exp_rx[1:0], rx_got[5:0]})
            `CHK(rx_sop, rx_got == 0)
            rx_got++;
        end
        if (done) done_cnt++;
        if (lrise) rise_cnt++;
    end
    ////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one tx cell; room vanishes mid-cell, the select polls port poll during it
    task automatic send_cell(input logic [4:0] port, input logic [4:0] poll);
        int n;
        exp_tx  = port;
        tx_got  = 0;
        tx_idx  = 6'h00;
        tx_port = port;
        tx_req  = 1'b1;
        for (n = 0; n < 100 && tx_busy !== 1'b1; n++) @(negedge clk);
        tx_req  = 1'b0;
        tx_port = poll;
        cyc(3);
        `CHK(link.tx_polled_room_flag, 1'b1)
        tx_room[port[1:0]] = 1'b0;
        cyc(3);
        `CHK(link.tx_polled_room_flag, poll != port)
        `CHK(link.tx_direct_room_flag, tx_room)
        for (n = 0; n < 200 && tx_busy !== 1'b0; n++) @(negedge clk);
        cyc(3);
        tx_room[port[1:0]] = 1'b1;
        `CHK(tx_got, UCP_CELL_BYTES)
    endtask
    // one rx cell; cell ready cleared once taken
    task automatic recv_cell(input logic [4:0] port);
        int n;
        exp_rx             = port;
        rx_got             = 0;
        rx_ready[port[1:0]] = 1'b1;
        rx_port            = port;
        rx_req             = 1'b1;
        for (n = 0; n < 100 && rx_busy !== 1'b1; n++) @(negedge clk);
        rx_req = 1'b0;
        cyc(3);
        `CHK(link.rx_polled_cell_ready, 1'b1)
        rx_ready[port[1:0]] = 1'b0;
        cyc(3);
        `CHK(link.rx_polled_cell_ready, 1'b0)
        for (n = 0; n < 200 && rx_busy !== 1'b0; n++) @(negedge clk);
        cyc(3);
        `CHK(rx_got, UCP_CELL_BYTES)
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        cyc(2);
        `CHK(link.tx_direct_room_flag, 4'h0)
        `CHK(link.tx_port_select, UCP_NULL_ADDR)
        rst_n = 1'b1;
        cyc(1);
        `CHK(link.tx_direct_room_flag, 4'hF)
        tx_room = 4'h5;
        cyc(1);
        `CHK(link.tx_direct_room_flag, 4'h5)
        tx_room = 4'hF;
        send_cell(UCP_FIRST_PORT, UCP_FIRST_PORT);
        send_cell(5'h03, 5'h03);
        send_cell(5'h03, 5'h01);
        recv_cell(5'h02);
        recv_cell(5'h01);
        `CHK(done_cnt, 2)
        r0 = rise_cnt;
        cyc(80);
        `CHK(rise_cnt - r0, 10)
        final_report;
    end
    // watchdog, run needs about 380 cycles
    initial begin
        #200000;
        num_errors++;
        final_report;
    end
endmodule
`default_nettype wire
